// *** hw/adc_mux_ctrl.sv ***
// module: converter mux decode, conversion timing and serial result port
`timescale 1ns/1ps
// Notes on behaviour
// - com 0, differential: select pairs 0/1..6/7; odd bit swaps polarity.
// - com 0, single-ended: positive even or odd channel, negative is ground.
// - com 1, single-ended: positive as single-ended, negative is channel 7 pin.
// - com high: single-ended uses channel 7 pin as the shared negative; differential, or channel 7 as positive, sets cfg_illegal.
// - a rising edge of select_and_convert_in starts a conversion when idle and slp is clear.
// - after conversion, input low opens port; result shifts out on sck.
// - bipolar gives two's complement, unipolar gives straight binary.
// - conversion lasts 3 us typical, at most 3.5 us; host waits.
// - throughput up to 200 ksps; host must not start faster.
// - config word shifted in sd, os, s1, s0, com, uni, slp.
// - start edges during a conversion are ignored.
module adc_mux_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int DATA_W = RESULT_W,
  parameter int CONV_CYC = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  // link side, on the host shift clock
  input wire logic sck,
  input wire logic select_and_convert_in,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // raw sample from the analog core, two's complement about mid-scale
  input wire logic [DATA_W-1:0] sample_in,
  // status and mux control
  output logic [CHAN_W-1:0] mux_pos_chan,
  output logic mux_neg_is_chan,
  output logic [CHAN_W-1:0] mux_neg_chan,
  output logic mux_neg_is_common,
  output logic cfg_illegal,
  output logic sleep_active,
  output logic converting,
  output logic overrun
);

  // ----------------------------------------------------------------
  // link domain: configuration shift-in and result shift-out
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_shift_reg;
  logic [2:0] cfg_cnt_reg;
  logic cfg_loaded_reg;
  logic [CFG_W-1:0] cfg_hold_reg;
  logic [DATA_W-1:0] tx_shift_reg;
  logic tx_load_reg;
  logic [DATA_W-1:0] tx_word_hold;

  // frame: clock shifts only while the select input is low
  always_ff @(posedge sck or posedge select_and_convert_in) begin
    if (select_and_convert_in) begin
      cfg_shift_reg <= '0;
      cfg_cnt_reg <= '0;
      cfg_loaded_reg <= 1'b0;
    end else if (cfg_cnt_reg != 3'(CFG_W)) begin
      cfg_shift_reg <= {cfg_shift_reg[CFG_W-2:0], sdi};
      cfg_cnt_reg <= cfg_cnt_reg + 1'b1;
      cfg_loaded_reg <= (cfg_cnt_reg == 3'(CFG_W-1));
    end
  end

  always_ff @(posedge sck) begin
    if (!select_and_convert_in && cfg_cnt_reg == 3'(CFG_W-1)) begin
      cfg_hold_reg <= {cfg_shift_reg[CFG_W-2:0], sdi};
    end
  end

  // output shifts on the falling shift clock edge, msb first
  always_ff @(negedge sck or posedge select_and_convert_in) begin
    if (select_and_convert_in) begin
      tx_load_reg <= 1'b1;
      tx_shift_reg <= '0;
    end else if (tx_load_reg) begin
      tx_load_reg <= 1'b0;
      tx_shift_reg <= {tx_word_hold[DATA_W-2:0], 1'b0};
    end else begin
      tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // crossings into clk
  // ----------------------------------------------------------------
  logic [1:0] cs_sync_reg;
  logic cs_prev_reg;
  logic [2:0] load_sync_reg;
  logic cfg_commit;
  logic start_edge;

  // select idles high, so the edge detector resets high: no false start
  // loaded flag holds until frame end: keep frame open 3 clk past bit 7
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_sync_reg <= 2'h3;
      cs_prev_reg <= 1'b1;
      load_sync_reg <= '0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], select_and_convert_in};
      cs_prev_reg <= cs_sync_reg[1];
      load_sync_reg <= {load_sync_reg[1:0], cfg_loaded_reg};
    end
  end

  assign start_edge = cs_sync_reg[1] && !cs_prev_reg;
  assign cfg_commit = load_sync_reg[1] && !load_sync_reg[2];

  // ----------------------------------------------------------------
  // configuration and mux decode
  // ----------------------------------------------------------------
  cfg_word_s cfg_reg;
  cfg_word_s cfg_next;
  mux_sel_s mux_next;
  logic [CHAN_W-1:0] pair_even;

  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_commit) begin
      cfg_next = cfg_word_s'(cfg_hold_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg <= cfg_word_s'(CFG_RESET);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign pair_even = {cfg_reg.chan_sel_hi, cfg_reg.chan_sel_lo, 1'b0};

  always_comb begin
    mux_next = '0;
    mux_next.pos_chan = pair_even | CHAN_W'(cfg_reg.odd_sign_sel);
    if (!cfg_reg.single_diff_sel) begin
      // differential pair, odd bit swaps members
      mux_next.neg_is_chan = 1'b1;
      mux_next.neg_chan = pair_even | CHAN_W'(!cfg_reg.odd_sign_sel);
      if (cfg_reg.common_sel) begin
        mux_next.illegal = 1'b1;
      end
    end else if (cfg_reg.common_sel) begin
      // channel 7 pin is the shared negative
      mux_next.neg_is_common = 1'b1;
      if (mux_next.pos_chan == 3'h7) begin
        mux_next.illegal = 1'b1;
      end
    end else begin
      // single-ended to ground
      mux_next.neg_is_chan = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mux_pos_chan <= '0;
      mux_neg_is_chan <= 1'b0;
      mux_neg_chan <= '0;
      mux_neg_is_common <= 1'b0;
      cfg_illegal <= 1'b0;
      sleep_active <= 1'b0;
    end else begin
      mux_pos_chan <= mux_next.pos_chan;
      mux_neg_is_chan <= mux_next.neg_is_chan;
      mux_neg_chan <= mux_next.neg_chan;
      mux_neg_is_common <= mux_next.neg_is_common;
      cfg_illegal <= mux_next.illegal;
      sleep_active <= cfg_reg.sleep_request;
    end
  end

  // ----------------------------------------------------------------
  // conversion timer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} conv_state_e;
  conv_state_e state_reg;
  logic [15:0] conv_cnt_reg;
  logic [DATA_W-1:0] result_word;
  logic push_valid;
  logic push_ready;
  logic [DATA_W-1:0] pop_data;
  logic pop_valid;
  logic pop_ready;

  // bipolar keeps two's complement, unipolar flips the msb
  assign result_word = cfg_reg.unipolar_sel
    ? {~sample_in[DATA_W-1], sample_in[DATA_W-2:0]} : sample_in;
  assign push_valid = (state_reg == ST_DONE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_edge && !cfg_reg.sleep_request) begin
            state_reg <= ST_CONV;
            conv_cnt_reg <= 16'(CONV_CYC - 1);
          end
        end
        ST_CONV: begin
          // further start edges ignored here
          if (conv_cnt_reg == '0) begin
            state_reg <= ST_DONE;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - 1'b1;
          end
        end
        ST_DONE: begin
          if (push_ready) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converting <= 1'b0;
      overrun <= 1'b0;
    end else begin
      converting <= (state_reg != ST_IDLE);
      // a start edge while busy is dropped and flagged
      overrun <= overrun || (start_edge && state_reg != ST_IDLE);
    end
  end

  result_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(result_word),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(pop_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready)
  );

  // ----------------------------------------------------------------
  // hand the oldest result to the link: held stable while frame open
  // ----------------------------------------------------------------
  logic cs_low_seen_reg;
  logic sdo_meta_reg;
  assign pop_ready = pop_valid && cs_sync_reg[1] && cs_low_seen_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_word_hold <= '0;
      cs_low_seen_reg <= 1'b1;
    end else begin
      if (pop_ready) begin
        tx_word_hold <= pop_data;
      end
      if (!cs_sync_reg[1]) begin
        cs_low_seen_reg <= 1'b1;
      end else if (pop_ready) begin
        cs_low_seen_reg <= 1'b0;
      end
    end
  end

  // msb drives at once when the frame opens, later bits from shift
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdo_meta_reg <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_meta_reg <= tx_load_reg ? tx_word_hold[DATA_W-1]
        : tx_shift_reg[DATA_W-1];
      sdo <= sdo_meta_reg;
      sdo_oe <= !cs_sync_reg[1] && (state_reg == ST_IDLE);
    end
  end

endmodule : adc_mux_ctrl

// *** hw/result_fifo.sv ***
// module: result word fifo with valid and ready on both sides
`timescale 1ns/1ps
module result_fifo
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = RESULT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : result_fifo

// *** shared/adc_ctrl_pkg.sv ***
// package: constants and types for the converter control block
package adc_ctrl_pkg;

  localparam int RESULT_W = 16;
  localparam int CFG_W = 7;
  localparam int CHAN_W = 3;

  // configuration word bit positions, first shifted bit is the msb
  localparam int CFG_SD_POS = 6;
  localparam int CFG_OS_POS = 5;
  localparam int CFG_S1_POS = 4;
  localparam int CFG_S0_POS = 3;
  localparam int CFG_COM_POS = 2;
  localparam int CFG_UNI_POS = 1;
  localparam int CFG_SLP_POS = 0;
  localparam logic [6:0] CFG_RESET = 7'h00;

  // timing
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_MAX_NS = 3500;
  localparam int CONV_CYCLES = (CONV_TIME_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
  localparam int MIN_CYCLES = 1;

  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic single_diff_sel;
    logic odd_sign_sel;
    logic chan_sel_hi;
    logic chan_sel_lo;
    logic common_sel;
    logic unipolar_sel;
    logic sleep_request;
  } cfg_word_s;

  typedef struct packed {
    logic [CHAN_W-1:0] pos_chan;
    logic neg_is_chan;
    logic [CHAN_W-1:0] neg_chan;
    logic neg_is_common;
    logic illegal;
  } mux_sel_s;

endpackage : adc_ctrl_pkg

// *** tb/adc_mux_ctrl_assertions.sv ***
// checker: decode and timing relations at the converter control ports
`timescale 1ns/1ps
module adc_mux_ctrl_checker
  import adc_ctrl_pkg::*;
#(
  parameter int DATA_W = RESULT_W,
  parameter int CONV_CYC = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic select_and_convert_in,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [DATA_W-1:0] sample_in,
  input wire logic [CHAN_W-1:0] mux_pos_chan,
  input wire logic mux_neg_is_chan,
  input wire logic [CHAN_W-1:0] mux_neg_chan,
  input wire logic mux_neg_is_common,
  input wire logic cfg_illegal,
  input wire logic sleep_active,
  input wire logic converting,
  input wire logic overrun
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_pair_partner: assert property (
    mux_neg_is_chan |-> mux_neg_chan == (mux_pos_chan ^ 3'h1))
    else $error("negative input is not the pair partner");
  chk_common_excl: assert property (
    mux_neg_is_common |-> !mux_neg_is_chan)
    else $error("common and channel negative both set");
  chk_common_no_ch7: assert property (
    mux_neg_is_common && !cfg_illegal |-> mux_pos_chan != 3'h7)
    else $error("channel 7 measured while it is common");
  chk_start_conv: assert property (
    $rose(select_and_convert_in) && !converting && !sleep_active
    |-> ##[1:4] converting)
    else $error("start edge did not start a conversion");
  chk_conv_bound: assert property (
    $rose(converting) |-> ##[1:72] !converting)
    else $error("conversion too long");
  chk_busy_ignore: assert property (
    $rose(select_and_convert_in) ##1 converting [*3] |-> ##[0:2] overrun)
    else $error("start edge while busy not refused");
  chk_overrun_sticky: assert property (
    overrun |=> overrun)
    else $error("overrun cleared without reset");
  chk_quiet_busy: assert property (
    converting |-> !sdo_oe)
    else $error("serial output driven during conversion");
  chk_oe_release: assert property (
    select_and_convert_in [*4] |-> !sdo_oe)
    else $error("serial output driven with port closed");
endmodule : adc_mux_ctrl_checker

bind adc_mux_ctrl adc_mux_ctrl_checker #(
  .DATA_W(DATA_W),
  .CONV_CYC(CONV_CYC)
) u_chk (
  .clk, .sys_rst, .sck, .select_and_convert_in, .sdi, .sdo, .sdo_oe,
  .sample_in, .mux_pos_chan, .mux_neg_is_chan, .mux_neg_chan,
  .mux_neg_is_common, .cfg_illegal, .sleep_active, .converting, .overrun
);

// *** tb/host_serial_model.sv ***
// host serial controller model: frames, shift clock, config and result
`timescale 1ns/1ps
module host_serial_model (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic converting,
  output logic sck,
  output logic select_and_convert_in,
  output logic sdi
);
  logic [15:0] word;
  logic oe_mid;
  int waits;

  initial begin
    sck = 1'b0;
    select_and_convert_in = 1'b0;
    sdi = 1'b0;
    waits = 0;
    oe_mid = 1'b0;
    // a clean rising edge resets the link-side registers, all but cfg_hold_reg, at start
    #1 select_and_convert_in = 1'b1;
  end

  // one frame: config in msb first, result out, then a new start
  task automatic xfer(input logic [6:0] cfg);
    @(posedge clk) select_and_convert_in <= 1'b0;
    repeat (5) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      #1 word[i] = sdo;
      if (i == 8) oe_mid = sdo_oe;
      // past the config bits the line toggles like a released line
      sdi <= (i > 8) ? cfg[i-9] : ~sdi;
      #6 sck = 1'b1;
      #3 sck = 1'b0;
      repeat (5) @(posedge clk);
    end
    @(posedge clk) select_and_convert_in <= 1'b1;
    repeat (4) @(posedge clk);
    waits = 0;
    while (converting === 1'b1 && waits < 200) begin
      @(posedge clk);
      waits++;
    end
    repeat (30) @(posedge clk);
  endtask : xfer

  // a start edge 2 clk after select drops, with no shift clock
  task automatic early_start();
    @(posedge clk) select_and_convert_in <= 1'b0;
    repeat (2) @(posedge clk);
    select_and_convert_in <= 1'b1;
  endtask : early_start
endmodule : host_serial_model

// *** tb/tb_top.sv ***
// testbench: mux decode table, result format, sleep and busy refusal
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] sample_in = 16'h0000;
  logic sck, select_and_convert_in, sdi, sdo, sdo_oe;
  logic [2:0] mux_pos_chan, mux_neg_chan, p;
  logic mux_neg_is_chan, mux_neg_is_common, cfg_illegal, bad;
  logic sleep_active, converting, overrun;
  logic [4:0] c;
  int mismatches = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  adc_mux_ctrl #(.CONV_CYC(8)) u_dut (
    .clk, .sys_rst, .sck, .select_and_convert_in, .sdi, .sdo, .sdo_oe,
    .sample_in, .mux_pos_chan, .mux_neg_is_chan, .mux_neg_chan,
    .mux_neg_is_common, .cfg_illegal, .sleep_active, .converting, .overrun
  );
  host_serial_model u_host (
    .clk, .sdo, .sdo_oe, .converting, .sck, .select_and_convert_in, .sdi
  );

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic run(input logic [6:0] cfg);
    u_host.xfer(cfg);
    #1;
    if (u_host.waits >= 200) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : run

  // every sd, os, s1, s0, com combination
  task automatic decode_table();
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      p = {c[2:1], c[3]};
      bad = c[0] & (!c[4] | (p == 3'h7));
      run({c, 2'b00});
      check("illegal", bad, cfg_illegal);
      if (!bad) begin
        check("pos", p, mux_pos_chan);
        check("neg is chan", !c[4], mux_neg_is_chan);
        check("common", c[0], mux_neg_is_common);
        if (!c[4])
          check("neg", p ^ 3'h1, mux_neg_chan);
      end
    end
  endtask : decode_table

  task automatic result_format();
    @(posedge clk) sample_in <= 16'h1234;
    run(7'h40);
    run(7'h40);
    check("bipolar word", 16'h1234, u_host.word);
    check("oe in frame", 1'b1, u_host.oe_mid);
    check("oe closed", 1'b0, sdo_oe);
    @(posedge clk) sample_in <= 16'hF00D;
    run(7'h42);
    run(7'h42);
    check("unipolar word", 16'h700D, u_host.word);
  endtask : result_format

  task automatic sleep_and_busy();
    run(7'h41);
    check("sleep", 1'b1, sleep_active);
    check("no start asleep", 1'b0, converting);
    run(7'h40);
    check("awake", 1'b0, sleep_active);
    u_host.early_start();
    u_host.early_start();
    repeat (2) @(posedge clk);
    #1;
    check("busy", 1'b1, converting);
    repeat (6) @(posedge clk);
    #1;
    check("overrun", 1'b1, overrun);
  endtask : sleep_and_busy

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    decode_table();
    result_format();
    sleep_and_busy();
    tally_and_finish();
  end
endmodule : tb_top
